// File: pkg/rxpe_cfg_if.sv
// per-port video option fields and truncation status
`timescale 1ns/1ps
interface rxpe_cfg_if;
  logic [1:0] raw_sel;
  logic trunc_par;
  logic trunc_line;
  logic trunc_frame;
  logic auto_pol;
  logic lv_sense;
  logic fv_sense;
  logic truncating;
  modport regs (output raw_sel, trunc_par, trunc_line, trunc_frame,
    auto_pol, lv_sense, fv_sense, input truncating);
  modport video (input raw_sel, trunc_par, trunc_line, trunc_frame,
    auto_pol, lv_sense, fv_sense, output truncating);
endinterface

// File: pkg/rxpe_pkg.sv
// constants and types for the per-port packet error and video option group
package rxpe_pkg;
  localparam int NPORTS = 4;
  localparam logic [7:0] ADDR_PORT_SEL = 8'h4c;
  localparam logic [7:0] ADDR_MAILBOX = 8'h79;
  localparam logic [7:0] ADDR_FLAGS = 8'h7a;
  localparam logic [7:0] ADDR_COUNT = 8'h7b;
  localparam logic [7:0] ADDR_OPTS = 8'h7c;
  localparam logic [1:0] PORT_SEL_RST = 2'h0;
  localparam logic [7:0] MAILBOX_RST = 8'h01;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] OPTS_RST = 8'h20;
  localparam int FLG_LEN = 3;
  localparam int FLG_CKSUM = 2;
  localparam int FLG_ECC2 = 1;
  localparam int FLG_ECC1 = 0;
  localparam int OPT_RAW_HI = 7;
  localparam int OPT_RAW_LO = 6;
  localparam int OPT_TRUNC_PAR = 5;
  localparam int OPT_TRUNC_LINE = 4;
  localparam int OPT_TRUNC_FRAME = 3;
  localparam int OPT_AUTO_POL = 2;
  localparam int OPT_LV_SENSE = 1;
  localparam int OPT_FV_SENSE = 0;
  localparam logic [1:0] RAW_UPPER8 = 2'h2;
  localparam logic [1:0] RAW_LOWER8 = 2'h3;
  // header ecc column codes, data bit 23 first
  localparam logic [23:0][5:0] ECC_COL = {
    6'h3b, 6'h37, 6'h2f, 6'h1f, 6'h38, 6'h34, 6'h32, 6'h31,
    6'h2c, 6'h2a, 6'h29, 6'h26, 6'h25, 6'h23, 6'h1c, 6'h1a,
    6'h19, 6'h16, 6'h15, 6'h13, 6'h0e, 6'h0d, 6'h0b, 6'h07};

  typedef struct packed {
    logic [1:0] port_sel;
    logic [NPORTS-1:0][7:0] mailbox;
    logic [NPORTS-1:0][3:0] flags;
    logic [NPORTS-1:0][7:0] count;
    logic [NPORTS-1:0][7:0] opts;
    logic [7:0] rdata;
    logic [NPORTS-1:0] hdr_valid;
    logic [NPORTS-1:0][23:0] hdr_data;
    logic [NPORTS-1:0] hdr_bad;
  } rxpe_top_state_t;

  typedef enum logic [3:0] {
    VS_FWD = 4'b0001,
    VS_DROP = 4'b0010,
    VS_WAIT = 4'b0100,
    VS_DISC = 4'b1000
  } rxpe_vstate_t;

  typedef struct packed {
    rxpe_vstate_t state;
    logic [1:0] frames;
    logic lv_sense;
    logic fv_sense;
    logic auto_prev;
    logic fv_prev;
    logic [9:0] pix;
    logic lv;
    logic fv;
    logic valid;
  } rxpe_video_state_t;
endpackage

// File: rtl/rxpe_top.sv
// per-port register group: mailbox, packet error flags, count, options
`timescale 1ns/1ps
module rxpe_top
  import rxpe_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // register access from the i2c target
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // packet headers and payload checks per port
  input wire logic [NPORTS-1:0] hdr_valid,
  input wire logic [NPORTS-1:0][23:0] hdr_data,
  input wire logic [NPORTS-1:0][5:0] hdr_ecc,
  input wire logic [NPORTS-1:0] len_err,
  input wire logic [NPORTS-1:0] payload_checksum_fault_flag,
  // corrected headers per port
  output logic [NPORTS-1:0] hdr_out_valid,
  output logic [NPORTS-1:0][23:0] hdr_out_data,
  output logic [NPORTS-1:0] hdr_out_bad,
  // incoming video per port
  input wire logic [NPORTS-1:0] raw10_mode,
  input wire logic [NPORTS-1:0] pix_valid,
  input wire logic [NPORTS-1:0][9:0] pix_in,
  input wire logic [NPORTS-1:0] lv_in,
  input wire logic [NPORTS-1:0] fv_in,
  input wire logic [NPORTS-1:0] par_err,
  input wire logic [NPORTS-1:0] line_chg,
  input wire logic [NPORTS-1:0] frame_chg,
  input wire logic [NPORTS-1:0] rx_lock,
  input wire logic [NPORTS-1:0][1:0] pass_thr,
  // forwarded video per port
  output logic [NPORTS-1:0] pix_out_valid,
  output logic [NPORTS-1:0][9:0] pix_out,
  output logic [NPORTS-1:0] lv_out,
  output logic [NPORTS-1:0] fv_out,
  output logic [NPORTS-1:0] frame_trunc
);
  rxpe_top_state_t s_reg, s_next;

  function automatic logic [5:0] ecc_calc(input logic [23:0] d);
    logic [5:0] e;
    e = 6'h00;
    for (int b = 0; b < 24; b++) begin
      if (d[b]) e = e ^ ECC_COL[b];
    end
    return e;
  endfunction

  // hardware set always wins over the read clear
  function automatic logic [3:0] flag_next(input logic [3:0] cur,
      input logic [3:0] set, input logic clr);
    return (cur & ~{4{clr}}) | set;
  endfunction

  logic [5:0] syn;
  logic [23:0] fixd;
  logic hit;
  logic [3:0] set;
  logic rd_flags, rd_count, rd_hit;
  logic [7:0] cnt;

  always_comb begin
    s_next = s_reg;
    syn = 6'h00;
    fixd = 24'h000000;
    hit = 1'b0;
    set = 4'h0;
    rd_hit = 1'b0;
    cnt = 8'h00;
    rd_flags = reg_rd && (reg_addr == ADDR_FLAGS);
    rd_count = reg_rd && (reg_addr == ADDR_COUNT);
    s_next.hdr_valid = '0;
    for (int p = 0; p < NPORTS; p++) begin
      syn = ecc_calc(hdr_data[p]) ^ hdr_ecc[p];
      fixd = hdr_data[p];
      hit = 1'b0;
      for (int b = 0; b < 24; b++) begin
        if (syn == ECC_COL[b]) begin
          fixd[b] = ~fixd[b];
          hit = 1'b1;
        end
      end
      // a lone syndrome bit means only the ecc byte was hit
      if ($countones(syn) == 1) hit = 1'b1;
      set = 4'h0;
      set[FLG_LEN] = len_err[p];
      set[FLG_CKSUM] = payload_checksum_fault_flag[p];
      if (hdr_valid[p] && syn != 6'h00) begin
        set[FLG_ECC1] = hit;
        set[FLG_ECC2] = ~hit;
      end
      s_next.hdr_valid[p] = hdr_valid[p];
      // multi-bit headers leave as received, only marked bad
      s_next.hdr_data[p] = hit ? fixd : hdr_data[p];
      s_next.hdr_bad[p] = hdr_valid[p] && syn != 6'h00 && !hit;
      rd_hit = (s_reg.port_sel == p[1:0]);
      s_next.flags[p] = flag_next(s_reg.flags[p], set,
        rd_flags && rd_hit);
      cnt = s_reg.count[p];
      if (rd_count && rd_hit) begin
        cnt = COUNT_RST;
      end
      if (set != 4'h0 && cnt != COUNT_MAX) begin
        cnt = cnt + 8'h01;
      end
      s_next.count[p] = cnt;
    end
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_PORT_SEL: s_next.port_sel = reg_wdata[1:0];
        ADDR_MAILBOX: s_next.mailbox[s_reg.port_sel] = reg_wdata;
        ADDR_OPTS: s_next.opts[s_reg.port_sel] = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_PORT_SEL: s_next.rdata = {6'h00, s_reg.port_sel};
        ADDR_MAILBOX: s_next.rdata = s_reg.mailbox[s_reg.port_sel];
        ADDR_FLAGS:
          s_next.rdata = {4'h0, s_reg.flags[s_reg.port_sel]};
        ADDR_COUNT: s_next.rdata = s_reg.count[s_reg.port_sel];
        ADDR_OPTS: s_next.rdata = s_reg.opts[s_reg.port_sel];
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_reg <= '{port_sel: PORT_SEL_RST,
        mailbox: {NPORTS{MAILBOX_RST}},
        flags: {NPORTS{FLAGS_RST}},
        count: {NPORTS{COUNT_RST}},
        opts: {NPORTS{OPTS_RST}},
        default: '0};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign hdr_out_valid = s_reg.hdr_valid;
  assign hdr_out_data = s_reg.hdr_data;
  assign hdr_out_bad = s_reg.hdr_bad;

  rxpe_cfg_if cfg_bus[NPORTS]();

  for (genvar i = 0; i < NPORTS; i++) begin : g_port
    assign cfg_bus[i].raw_sel = s_reg.opts[i][OPT_RAW_HI:OPT_RAW_LO];
    assign cfg_bus[i].trunc_par = s_reg.opts[i][OPT_TRUNC_PAR];
    assign cfg_bus[i].trunc_line = s_reg.opts[i][OPT_TRUNC_LINE];
    assign cfg_bus[i].trunc_frame = s_reg.opts[i][OPT_TRUNC_FRAME];
    assign cfg_bus[i].auto_pol = s_reg.opts[i][OPT_AUTO_POL];
    assign cfg_bus[i].lv_sense = s_reg.opts[i][OPT_LV_SENSE];
    assign cfg_bus[i].fv_sense = s_reg.opts[i][OPT_FV_SENSE];
    assign frame_trunc[i] = cfg_bus[i].truncating;

    rxpe_video u_video (
      .core_clk(core_clk),
      .reset(reset),
      .ce(ce),
      .cfg(cfg_bus[i]),
      .raw10_mode(raw10_mode[i]),
      .pix_valid(pix_valid[i]),
      .pix_in(pix_in[i]),
      .lv_in(lv_in[i]),
      .fv_in(fv_in[i]),
      .par_err(par_err[i]),
      .line_chg(line_chg[i]),
      .frame_chg(frame_chg[i]),
      .rx_lock(rx_lock[i]),
      .pass_thr(pass_thr[i]),
      .pix_out_valid(pix_out_valid[i]),
      .pix_out(pix_out[i]),
      .lv_out(lv_out[i]),
      .fv_out(fv_out[i])
    );
  end
endmodule // rxpe_top

// File: rtl/rxpe_video.sv
// per-port video path: bit reduction, polarity, frame truncation
`timescale 1ns/1ps
module rxpe_video
  import rxpe_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // options from the register group
  rxpe_cfg_if.video cfg,
  // incoming video
  input wire logic raw10_mode,
  input wire logic pix_valid,
  input wire logic [9:0] pix_in,
  input wire logic lv_in,
  input wire logic fv_in,
  // link events and pass qualification
  input wire logic par_err,
  input wire logic line_chg,
  input wire logic frame_chg,
  input wire logic rx_lock,
  input wire logic [1:0] pass_thr,
  // forwarded video
  output logic pix_out_valid,
  output logic [9:0] pix_out,
  output logic lv_out,
  output logic fv_out
);
  rxpe_video_state_t s_reg, s_next;
  logic lvs, fvs, lvn, fvn, fend, cut_frame, cut_lp;
  logic [1:0] cnt_inc;

  always_comb begin
    s_next = s_reg;
    lvs = cfg.auto_pol ? s_reg.lv_sense : cfg.lv_sense;
    fvs = cfg.auto_pol ? s_reg.fv_sense : cfg.fv_sense;
    lvn = lv_in ^ lvs;
    fvn = fv_in ^ fvs;
    fend = s_reg.fv_prev & ~fvn;
    cut_frame = cfg.trunc_frame & frame_chg;
    cut_lp = (cfg.trunc_par & par_err)
      | (cfg.trunc_line & line_chg);
    cnt_inc = s_reg.frames + 2'h1;
    s_next.fv_prev = fvn;
    s_next.auto_prev = cfg.auto_pol;
    unique case (s_reg.state)
      VS_FWD: begin
        if (cut_frame) begin
          s_next.state = VS_WAIT;
          s_next.frames = 2'h0;
        end else if (cut_lp) begin
          s_next.state = VS_DROP;
        end
      end
      VS_DROP: begin
        if (cut_frame) begin
          s_next.state = VS_WAIT;
          s_next.frames = 2'h0;
        end else if (fend) begin
          s_next.state = VS_FWD;
        end
      end
      VS_WAIT: begin
        // any enabled cut event restarts the frame count toward the threshold
        if (cut_frame | cut_lp) begin
          s_next.frames = 2'h0;
        end else if (pass_thr == 2'h0) begin
          if (rx_lock) s_next.state = VS_FWD;
        end else if (fend) begin
          s_next.frames = cnt_inc;
          if (cnt_inc >= pass_thr) s_next.state = VS_FWD;
        end
      end
      VS_DISC: begin
        if (fend) s_next.state = VS_FWD;
      end
      default: s_next.state = VS_FWD;
    endcase
    // the bus is assumed idle at blanking level when detection is enabled
    if (cfg.auto_pol & ~s_reg.auto_prev) begin
      s_next.lv_sense = lv_in;
      s_next.fv_sense = fv_in;
      // blanking is idle under the new sense: no false frame end
      s_next.fv_prev = 1'b0;
      s_next.state = VS_DISC;
    end
    s_next.valid = (s_reg.state == VS_FWD) & pix_valid;
    s_next.lv = (s_reg.state == VS_FWD) & lvn;
    s_next.fv = (s_reg.state == VS_FWD) & fvn;
    s_next.pix = pix_in;
    if (raw10_mode && cfg.raw_sel == RAW_UPPER8) begin
      s_next.pix = {2'h0, pix_in[9:2]};
    end else if (raw10_mode && cfg.raw_sel == RAW_LOWER8) begin
      s_next.pix = {2'h0, pix_in[7:0]};
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_reg <= '{state: VS_FWD, default: '0};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign cfg.truncating = (s_reg.state != VS_FWD);
  assign pix_out_valid = s_reg.valid;
  assign pix_out = s_reg.pix;
  assign lv_out = s_reg.lv;
  assign fv_out = s_reg.fv;
endmodule // rxpe_video

// File: test/rx_port_packet_err_video_cfg_tb_top.sv
// self-checking bench for the per-port register group
`timescale 1ns/1ps
module rx_port_packet_err_video_cfg_tb_top;
  import rxpe_pkg::*;
  logic core_clk, reset, ce, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [NPORTS-1:0] hdr_valid, len_err, payload_checksum_fault_flag, hdr_out_valid;
  logic [NPORTS-1:0] hdr_out_bad, raw10_mode, pix_valid, lv_in, fv_in;
  logic [NPORTS-1:0] par_err, line_chg, frame_chg, rx_lock, lv_out;
  logic [NPORTS-1:0] fv_out, pix_out_valid, frame_trunc;
  logic [NPORTS-1:0][23:0] hdr_data, hdr_out_data;
  logic [NPORTS-1:0][5:0] hdr_ecc;
  logic [NPORTS-1:0][9:0] pix_in, pix_out;
  logic [NPORTS-1:0][1:0] pass_thr;
  logic [23:0] d, f;
  logic [3:0] b;
  int err_count = 0, tests_run = 0, cyc = 0, p, i, k, e;
  int flg[NPORTS], cnt[NPORTS], mb[NPORTS];
  rxpe_top dut (.core_clk, .reset, .ce, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .hdr_valid, .hdr_data, .hdr_ecc, .len_err,
    .payload_checksum_fault_flag, .hdr_out_valid, .hdr_out_data, .hdr_out_bad, .raw10_mode,
    .pix_valid, .pix_in, .lv_in, .fv_in, .par_err, .line_chg, .frame_chg,
    .rx_lock, .pass_thr, .pix_out_valid, .pix_out, .lv_out, .fv_out,
    .frame_trunc);
  rxpe_cam_model cam (.core_clk, .hdr_valid, .hdr_data, .hdr_ecc,
    .len_err, .payload_checksum_fault_flag, .pix_valid, .pix_in, .lv_in, .fv_in, .par_err,
    .line_chg);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, dv);
    if (reg_rd) reg_rd = 1'b0;
    reg_addr = a;
    reg_wdata = dv;
    reg_wr = 1'b1;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    if (reg_wr) reg_wr = 1'b0;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    v = reg_rdata;
  endtask
  // strobes stay up across back-to-back transfers of one kind; wr drops reg_rd, rd drops reg_wr, and both drop here
  task automatic idle();
    if (reg_wr) reg_wr = 1'b0;
    if (reg_rd) reg_rd = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("tests_run %0d err_count %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, frame_chg, pass_thr} = '0;
    {reset, ce, raw10_mode, rx_lock} = '1;
    void'($urandom(32'he5c6f5cc));
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    for (p = 0; p < NPORTS; p++) begin
      wr(ADDR_PORT_SEL, 8'(p));
      rd(ADDR_MAILBOX);
      chk(v, 8'h01);
      rd(ADDR_COUNT);
      chk(v, 8'h00);
      rd(ADDR_OPTS);
      chk(v, 8'h20);
      mb[p] = $urandom_range(255);
      wr(ADDR_MAILBOX, 8'(mb[p]));
      wr(ADDR_FLAGS, 8'hff);
      rd(ADDR_FLAGS);
      chk(v, 8'h00);
    end
    for (p = 0; p < NPORTS; p++) begin
      wr(ADDR_PORT_SEL, 8'(p));
      rd(ADDR_MAILBOX);
      chk(v, mb[p]);
    end
    ce = 1'b0;
    wr(ADDR_MAILBOX, 8'h5a);
    ce = 1'b1;
    rd(ADDR_MAILBOX);
    chk(v, mb[NPORTS-1]);
    rd(8'h90);
    chk(v, 8'h00);
    $display("register access test done");
    for (i = 0; i < 40; i++) begin
      p = $urandom_range(NPORTS - 1);
      k = $urandom_range(2);
      e = $urandom_range(3);
      d = 24'($urandom);
      f = k == 2 ? 24'h3 : 24'(k) << $urandom_range(23);
      b = {2'(e), k == 2, k == 1};
      wr(ADDR_PORT_SEL, 8'(p));
      idle();
      cam.pkt(p, d, f, 2'(e));
      chk(hdr_out_data[p], k == 2 ? d ^ f : d);
      chk(hdr_out_bad[p], k == 2);
      chk(hdr_out_valid[p], 1'b1);
      flg[p] |= b;
      cnt[p] += (b != 0 && cnt[p] < 255);
      if ($urandom_range(1)) begin
        rd(ADDR_FLAGS);
        chk(v, flg[p]);
        flg[p] = 0;
      end
    end
    for (p = 0; p < NPORTS; p++) begin
      wr(ADDR_PORT_SEL, 8'(p));
      rd(ADDR_FLAGS);
      chk(v, flg[p]);
      rd(ADDR_COUNT);
      chk(v, cnt[p]);
    end
    wr(ADDR_PORT_SEL, 8'h00);
    idle();
    repeat (260) begin
      cam.pkt(0, 24'h0, 24'h0, 2'h2);
      @(negedge core_clk);
    end
    fork
      cam.pkt(0, 24'h0, 24'h0, 2'h2);
      rd(ADDR_COUNT);
    join
    chk(v, 8'hff);
    rd(ADDR_COUNT);
    chk(v, 8'h01);
    rd(ADDR_COUNT);
    chk(v, 8'h00);
    fork
      cam.pkt(0, 24'h0, 24'h0, 2'h1);
      rd(ADDR_FLAGS);
    join
    chk(v, 8'h08);
    rd(ADDR_FLAGS);
    chk(v, 8'h04);
    rd(ADDR_FLAGS);
    chk(v, 8'h00);
    idle();
    $display("packet error test done");
    for (k = 0; k < 4; k++) begin
      p = $urandom_range(NPORTS - 1);
      e = $urandom_range(3);
      d = 24'($urandom);
      wr(ADDR_PORT_SEL, 8'(p));
      wr(ADDR_OPTS, {2'(k), 4'h0, 2'(e)});
      rd(ADDR_OPTS);
      chk(v, {2'(k), 4'h0, 2'(e)});
      idle();
      {cam.pix_valid[p], cam.lv_in[p], cam.fv_in[p]} = {1'b1, d[11:10]};
      cam.pix_in[p] = d[9:0];
      repeat (2) @(negedge core_clk);
      chk(pix_out[p], k == 2 ? d[9:2] : k == 3 ? d[7:0] : d[9:0]);
      chk({lv_out[p], fv_out[p]}, d[11:10] ^ 2'(e));
    end
    for (k = 0; k < 4; k++) begin
      wr(ADDR_OPTS, k[1] ? {3'h0, k[0], 4'h0} : {2'h0, k[0], 5'h0});
      idle();
      cam.fv_in[p] = 1'b1;
      @(negedge core_clk);
      {cam.line_chg[p], cam.par_err[p]} = k[1] ? 2'h2 : 2'h1;
      @(negedge core_clk);
      {cam.line_chg[p], cam.par_err[p]} = 2'h0;
      @(negedge core_clk);
      chk({frame_trunc[p], pix_out_valid[p]}, {k[0], !k[0]});
      cam.fv_in[p] = 1'b0;
      repeat (4) @(negedge core_clk);
      chk(frame_trunc[p], 1'b0);
    end
    wr(ADDR_OPTS, 8'h08);
    idle();
    for (k = 0; k < 3; k++) begin
      rx_lock[p] = 1'b0;
      pass_thr[p] = 2'(k);
      frame_chg[p] = 1'b1;
      @(negedge core_clk);
      frame_chg[p] = 1'b0;
      for (i = 0; i < k; i++) begin
        @(negedge core_clk);
        chk(frame_trunc[p], 1'b1);
        cam.fv_in[p] = 1'b1;
        @(negedge core_clk);
        cam.fv_in[p] = 1'b0;
      end
      @(negedge core_clk);
      chk(frame_trunc[p], k == 0);
      rx_lock[p] = 1'b1;
      repeat (2) @(negedge core_clk);
      chk(frame_trunc[p], 1'b0);
    end
    {cam.lv_in[p], cam.fv_in[p]} = 2'h3;
    wr(ADDR_OPTS, 8'h04);
    idle();
    repeat (2) @(negedge core_clk);
    chk({frame_trunc[p], pix_out_valid[p]}, 2'h2);
    cam.fv_in[p] = 1'b0;
    @(negedge core_clk);
    cam.fv_in[p] = 1'b1;
    repeat (2) @(negedge core_clk);
    chk({frame_trunc[p], lv_out[p], fv_out[p]}, 3'h0);
    cam.fv_in[p] = 1'b0;
    @(negedge core_clk);
    chk(fv_out[p], 1'b1);
    reset = 1'b1;
    @(negedge core_clk);
    reset = 1'b0;
    rd(ADDR_MAILBOX);
    chk(v, 8'h01);
    rd(ADDR_OPTS);
    chk(v, 8'h20);
    idle();
    $display("video option test done");
    tally_and_finish();
  end
endmodule // rx_port_packet_err_video_cfg_tb_top

// File: test/rxpe_cam_model.sv
// camera-side model: packet headers with injected faults and raw video
`timescale 1ns/1ps
module rxpe_cam_model
  import rxpe_pkg::*;
(
  // clock
  input wire logic core_clk,
  // packet headers and payload checks
  output logic [NPORTS-1:0] hdr_valid,
  output logic [NPORTS-1:0][23:0] hdr_data,
  output logic [NPORTS-1:0][5:0] hdr_ecc,
  output logic [NPORTS-1:0] len_err,
  output logic [NPORTS-1:0] payload_checksum_fault_flag,
  // raw video and link events
  output logic [NPORTS-1:0] pix_valid,
  output logic [NPORTS-1:0][9:0] pix_in,
  output logic [NPORTS-1:0] lv_in,
  output logic [NPORTS-1:0] fv_in,
  output logic [NPORTS-1:0] par_err,
  output logic [NPORTS-1:0] line_chg
);
  initial begin
    {hdr_valid, hdr_data, hdr_ecc, len_err, payload_checksum_fault_flag} = '0;
    {pix_valid, pix_in, lv_in, fv_in, par_err, line_chg} = '0;
  end
  function automatic logic [5:0] ecc_of(input logic [23:0] d);
    ecc_of = 6'h0;
    for (int n = 0; n < 24; n++) ecc_of ^= d[n] ? ECC_COL[n] : 6'h0;
  endfunction
  // one header cycle; data goes inverse after, never the stale value
  task automatic pkt(input int p, input logic [23:0] d, f,
      input logic [1:0] e);
    hdr_valid[p] = 1'b1;
    hdr_data[p] = d ^ f;
    hdr_ecc[p] = ecc_of(d);
    {len_err[p], payload_checksum_fault_flag[p]} = e;
    @(negedge core_clk);
    hdr_valid[p] = 1'b0;
    {len_err[p], payload_checksum_fault_flag[p]} = 2'h0;
    hdr_data[p] = ~hdr_data[p];
  endtask
endmodule // rxpe_cam_model

// File: test/rxpe_top_assertions.sv
// assertions on the ports of the per-port register group
`timescale 1ns/1ps
module rxpe_top_chk
  import rxpe_pkg::*;
(
  // clock and register access
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // packet side
  input wire logic [NPORTS-1:0] hdr_valid,
  input wire logic [NPORTS-1:0] len_err,
  input wire logic [NPORTS-1:0] payload_checksum_fault_flag,
  input wire logic [NPORTS-1:0] hdr_out_valid,
  input wire logic [NPORTS-1:0] hdr_out_bad,
  input wire logic [NPORTS-1:0] frame_trunc
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [1:0] ps_reg;
  logic rd_f;
  logic rd_c;
  logic ev;
  // own copy of port select so reads tie to that port's events
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ps_reg <= 2'h0;
    end else if (ce && reg_wr && reg_addr == ADDR_PORT_SEL) begin
      ps_reg <= reg_wdata[1:0];
    end
  end
  assign rd_f = ce && reg_rd && reg_addr == ADDR_FLAGS;
  assign rd_c = ce && reg_rd && reg_addr == ADDR_COUNT;
  // conservative: any header may carry an ecc event
  assign ev = len_err[ps_reg] | payload_checksum_fault_flag[ps_reg] | hdr_valid[ps_reg];
  AST_RDATA_HOLD: assert property (
    !(ce && reg_rd) |=> $stable(reg_rdata)) else $error("rdata moved");
  AST_FLAGS_HI: assert property (
    rd_f |=> reg_rdata[7:4] == 4'h0) else $error("flag bits 7:4 set");
  AST_LEN_SET: assert property (
    ce && len_err[ps_reg] && !reg_wr ##1 rd_f |=> reg_rdata[FLG_LEN])
    else $error("length flag missing");
  AST_CKSUM_KEPT: assert property (
    rd_f && payload_checksum_fault_flag[ps_reg] && !reg_wr ##1 rd_f |=> reg_rdata[FLG_CKSUM])
    else $error("checksum flag lost in read");
  AST_FLAG_CLR: assert property (
    rd_f && !ev && !reg_wr ##1 rd_f |=> reg_rdata[3:0] == 4'h0)
    else $error("flags not cleared by read");
  AST_CNT_CLR: assert property (
    rd_c && !ev && !reg_wr ##1 rd_c |=> reg_rdata == 8'h00)
    else $error("count not cleared by read");
  AST_CNT_KEEP: assert property (
    rd_c && len_err[ps_reg] && !reg_wr ##1 rd_c |=> reg_rdata == 8'h01)
    else $error("count lost error in read");
  AST_BAD_CAUSE: assert property (
    ce && hdr_valid == '0 |=> (hdr_out_valid | hdr_out_bad) == '0)
    else $error("header out without header in");
  COV_BAD: cover property (|hdr_out_bad);
  COV_TRUNC: cover property (|frame_trunc);
  COV_FLAG: cover property (rd_f ##1 reg_rdata != 8'h00);
endmodule // rxpe_top_chk
bind rxpe_top rxpe_top_chk u_chk (.core_clk, .reset, .ce, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hdr_valid, .len_err,
  .payload_checksum_fault_flag, .hdr_out_valid, .hdr_out_bad, .frame_trunc);
